// ===== app_register_subset.sv
// Application register subset: stack, tag, compare, counters, loop state
// Overview of operation
// - Frame save base: 64-bit, software read only
// - Spill pointer: next spill address, read/write
// - Stack tag top bit reads zero, ignores writes
// - Wide data feeds stores, captures wide loads
// - Bits 61:60 optional without wide support
// - Compare value: 64-bit third exchange operand
// - User tag holds tags during spill/fill
// - Time counter: 64-bit, fixed clock ratio
// - Time counter reads strictly increase, except wrap
// - Secured time counter: fault unless most privileged
// - Legacy stamp read returns counter, else protection
// - Utilization counter advances only while active or last halter
// - Utilization increments sum to time increments
// - Utilization reads increase, except wrap
// - Secured utilization read faults unless privileged
// - Halted stops utilization, last halter counts
// - Utilization optional, feature bit, else reserved
// - Call copies frame, drain count, privilege
// - Return restores; privilege never raised
// - Caller state field layout, reserved bits
// - Loop count decrements on counted branches
// - Drain count 6 bits, upper bits ignored
// - Frame marker sizes at 6:0,13:7,17:14
`timescale 1ns/1ns
module app_register_subset
  import app_regs_pkg::*;
#(
  parameter int ITC_RATIO = 1,          // Core cycles per counter tick
  parameter bit WIDE_OPS_PRESENT = 1'b1, // Wide load/store support
  parameter bit UTIL_PRESENT = 1'b1     // Utilization counter fitted
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire ar_req_t ar_req,
  output logic [63:0] ar_rdata,
  output logic priv_fault,
  output logic reserved_fault,
  input wire logic itc_secure,
  input wire logic ruc_secure,
  input wire logic stamp_rd,
  output logic [63:0] stamp_data,
  output logic gp_fault,
  input wire logic rse_base_we,
  input wire logic [63:0] rse_base_data,
  input wire logic rse_spill_adv,
  input wire logic rse_tag_we,
  input wire logic [5:0] rse_tag_bit,
  input wire logic rse_tag_val,
  input wire logic wide_load_op,
  input wire logic [63:0] wide_load_hi,
  output logic [63:0] wide_store_hi,
  output logic [63:0] compare_operand,
  input wire logic spill_store_op,
  input wire logic fill_load_op,
  input wire logic [5:0] user_tag_collection_bit,
  input wire logic spill_tag_val,
  output logic fill_tag,
  input wire logic cpu_active,
  input wire logic last_halter,
  input wire logic call_branch,
  input wire logic return_branch,
  input wire logic [37:0] current_frame_marker,
  input wire logic [1:0] current_priv_level,
  output restore_t restore,
  output logic restore_valid,
  input wire logic loop_branch,
  output logic [5:0] drain_stage_count,
  output logic [63:0] feature_bits
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ITC_RATIO < 1 || ITC_RATIO > 65535) begin : g_bad_ratio
    $error("ITC_RATIO must lie in 1..65535");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [63:0] frame_base_ff; // Frame save base
  logic [63:0] spill_ptr_ff; // Spill pointer
  logic [63:0] stack_tag_ff; // Stack tag collection
  logic [63:0] wide_data_ff; // Wide store data
  logic [63:0] cmp_val_ff; // Compare value
  logic [63:0] user_tag_ff; // User tag collection
  logic [63:0] fp_status_ff; // Float status slot
  logic [63:0] itc_ff; // Interval time counter
  logic [63:0] ruc_ff; // Utilization counter
  caller_state_t pfs_ff; // Caller state save
  logic [63:0] lc_ff; // Loop iteration count
  logic [5:0] ec_ff; // Drain stage count
  logic [15:0] tick_ff; // Ratio divider
  logic tick; // Counter advance strobe
  logic [63:0] wide_mask; // Implemented wide bits
  logic wr_ok; // Write accepted
  logic wr_itc; // Time counter write
  logic [63:0] nxt_rdata; // Read mux result
  logic nxt_priv_fault; // Fault for this request
  logic nxt_rsv_fault; // Reserved access
  logic [1:0] ret_priv; // Privilege after return

  // Wide data bits 61:60 dropped when wide ops are absent
  // optional high bits
  assign wide_mask = WIDE_OPS_PRESENT ? 64'hFFFFFFFFFFFFFFFF :
                     64'hCFFFFFFFFFFFFFFF;

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  // Fixed ratio to the input clock, independent of issue rate
  // fixed ratio tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_ff <= RST_TICK;
    end else if (clk_en) begin
      if (tick) begin
        tick_ff <= RST_TICK;
      end else begin
        tick_ff <= tick_ff + 16'h0001;
      end
    end
  end
  assign tick = (tick_ff == 16'(ITC_RATIO - 1));

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Read mux, fault and reserved detection
  always_comb begin
    nxt_rdata = RST_WORD;
    nxt_priv_fault = 1'b0;
    nxt_rsv_fault = 1'b0;
    case (ar_req.index)
      IDX_FRAME_SAVE_BASE: nxt_rdata = frame_base_ff;
      IDX_SPILL_POINTER: nxt_rdata = spill_ptr_ff;
      IDX_STACK_TAG: nxt_rdata = stack_tag_ff;
      IDX_WIDE_STORE: nxt_rdata = wide_data_ff;
      IDX_COMPARE_VALUE: nxt_rdata = cmp_val_ff;
      IDX_USER_TAG: nxt_rdata = user_tag_ff;
      IDX_FLOAT_STATUS: nxt_rdata = fp_status_ff;
      IDX_INTERVAL_TIME: begin
        nxt_rdata = itc_ff;
        if ((ar_req.rd && itc_secure) || ar_req.wr) begin
          nxt_priv_fault = (ar_req.priv != MOST_PRIV);
        end
      end
      IDX_UTILIZATION: begin
        if (!UTIL_PRESENT) begin
          nxt_rsv_fault = ar_req.rd | ar_req.wr;
        end else begin
          nxt_rdata = ruc_ff;
          nxt_priv_fault = ar_req.rd && ruc_secure &&
                           (ar_req.priv != MOST_PRIV);
        end
      end
      IDX_CALLER_STATE: nxt_rdata = pfs_ff;
      IDX_LOOP_COUNT: nxt_rdata = lc_ff;
      IDX_DRAIN_COUNT: nxt_rdata = {58'h0, ec_ff};
      default: begin
        // Ignored windows read zero, the rest is reserved
        if (!((ar_req.index >= IDX_IGN_A_LO && ar_req.index <= IDX_IGN_A_HI)
            || ar_req.index >= IDX_IGN_B_LO)) begin
          nxt_rsv_fault = ar_req.rd | ar_req.wr;
        end
      end
    endcase
    if (nxt_priv_fault || nxt_rsv_fault) begin
      nxt_rdata = RST_WORD;
    end
  end

  assign wr_ok = ar_req.wr && !nxt_priv_fault && !nxt_rsv_fault;
  assign wr_itc = wr_ok && (ar_req.index == IDX_INTERVAL_TIME);

  // Read data and fault strobes, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ar_rdata <= RST_WORD;
      priv_fault <= 1'b0;
      reserved_fault <= 1'b0;
    end else if (clk_en) begin
      ar_rdata <= ar_req.rd ? nxt_rdata : RST_WORD;
      priv_fault <= nxt_priv_fault;
      reserved_fault <= nxt_rsv_fault;
    end
  end

  // ----------------------------------------------------------------
  // Stack engine registers
  // ----------------------------------------------------------------
  // Base only moves by the stack engine, software reads it
  // engine-loaded base
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_base_ff <= RST_WORD;
    end else if (clk_en && rse_base_we) begin
      frame_base_ff <= rse_base_data;
    end
  end

  // Spill pointer: software write, engine advance wins
  // spill pointer update
  always_ff @(posedge core_clk) begin
    if (reset) begin
      spill_ptr_ff <= RST_WORD;
    end else if (clk_en) begin
      if (rse_spill_adv) begin
        spill_ptr_ff <= spill_ptr_ff + SPILL_STEP;
      end else if (wr_ok && ar_req.index == IDX_SPILL_POINTER) begin
        spill_ptr_ff <= ar_req.wdata;
      end
    end
  end

  // Stack tag collection with its top bit held at zero
  // top bit forced zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stack_tag_ff <= RST_WORD;
    end else if (clk_en) begin
      if (wr_ok && ar_req.index == IDX_STACK_TAG) begin
        stack_tag_ff <= {1'b0, ar_req.wdata[STACK_TAG_TOP-1:0]};
      end
      if (rse_tag_we && rse_tag_bit != 6'(STACK_TAG_TOP)) begin
        stack_tag_ff[rse_tag_bit] <= rse_tag_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Wide data: load capture wins over a software write
  // wide load capture
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wide_data_ff <= RST_WORD;
    end else if (clk_en) begin
      if (wide_load_op) begin
        wide_data_ff <= wide_load_hi & wide_mask;
      end else if (wr_ok && ar_req.index == IDX_WIDE_STORE) begin
        wide_data_ff <= ar_req.wdata & wide_mask;
      end
    end
  end
  assign wide_store_hi = wide_data_ff;

  // Compare value and float status slots
  // compare operand store
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmp_val_ff <= RST_WORD;
      fp_status_ff <= RST_WORD;
    end else if (clk_en && wr_ok) begin
      if (ar_req.index == IDX_COMPARE_VALUE) begin
        cmp_val_ff <= ar_req.wdata;
      end
      if (ar_req.index == IDX_FLOAT_STATUS) begin
        fp_status_ff <= ar_req.wdata;
      end
    end
  end
  assign compare_operand = cmp_val_ff;

  // User tag: spill stores set a bit, fill loads read one out
  // spill and fill tags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      user_tag_ff <= RST_WORD;
      fill_tag <= 1'b0;
    end else if (clk_en) begin
      if (wr_ok && ar_req.index == IDX_USER_TAG) begin
        user_tag_ff <= ar_req.wdata;
      end
      if (spill_store_op) begin
        user_tag_ff[user_tag_collection_bit] <= spill_tag_val;
      end
      if (fill_load_op) begin
        fill_tag <= user_tag_ff[user_tag_collection_bit];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Time counter: privileged write, else one step per tick
  // monotonic time count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      itc_ff <= RST_WORD;
    end else if (clk_en) begin
      if (wr_itc) begin
        itc_ff <= ar_req.wdata;
      end else if (tick) begin
        itc_ff <= itc_ff + 64'h0000000000000001;
      end
    end
  end

  // Utilization counter, steps on the same tick while active or last halter
  // shares the time tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ruc_ff <= RST_WORD;
    end else if (clk_en && UTIL_PRESENT) begin
      if (tick && (cpu_active || last_halter)) begin
        ruc_ff <= ruc_ff + 64'h0000000000000001;
      end
    end
  end

  // Legacy stamp read path
  // stamp read or protection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stamp_data <= RST_WORD;
      gp_fault <= 1'b0;
    end else if (clk_en) begin
      gp_fault <= stamp_rd && itc_secure &&
                  (current_priv_level != MOST_PRIV);
      if (stamp_rd && !(itc_secure && current_priv_level != MOST_PRIV)) begin
        stamp_data <= itc_ff;
      end
    end
  end

  // Feature word: wide ops and utilization presence
  // presence bit
  always_comb begin
    feature_bits = RST_WORD;
    feature_bits[FEAT_WIDE_BIT] = WIDE_OPS_PRESENT;
    feature_bits[FEAT_UTIL_BIT] = UTIL_PRESENT;
  end

  // ----------------------------------------------------------------
  // Call, return and loop state
  // ----------------------------------------------------------------
  // Return never moves privilege to a more privileged level
  assign ret_priv = (pfs_ff.ppl > current_priv_level) ? pfs_ff.ppl :
                    current_priv_level;

  // Caller state save: call replaces all, write keeps reserved zero
  // call copies state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pfs_ff <= caller_state_t'(RST_WORD);
    end else if (clk_en) begin
      if (call_branch) begin
        pfs_ff <= '{ppl: current_priv_level, rv_hi: 4'h0, pec: ec_ff,
                    rv_lo: 14'h0000, pfm: current_frame_marker};
      end else if (wr_ok && ar_req.index == IDX_CALLER_STATE) begin
        pfs_ff <= '{ppl: ar_req.wdata[63:62], rv_hi: 4'h0,
                    pec: ar_req.wdata[57:52], rv_lo: 14'h0000,
                    pfm: ar_req.wdata[37:0]};
      end
    end
  end

  // Restore bundle presented on return
  // return restore
  always_ff @(posedge core_clk) begin
    if (reset) begin
      restore <= '{frame: 38'h0, drain: RST_DRAIN, priv: RST_PRIV};
      restore_valid <= 1'b0;
    end else if (clk_en) begin
      restore_valid <= return_branch;
      if (return_branch) begin
        restore <= '{frame: pfs_ff.pfm, drain: pfs_ff.pec, priv: ret_priv};
      end
    end
  end

  // Drain count: 6 bits, return restore wins over a write
  // six-bit drain count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ec_ff <= RST_DRAIN;
    end else if (clk_en) begin
      if (return_branch) begin
        ec_ff <= pfs_ff.pec;
      end else if (wr_ok && ar_req.index == IDX_DRAIN_COUNT) begin
        ec_ff <= ar_req.wdata[DRAIN_W-1:0];
      end
    end
  end
  assign drain_stage_count = ec_ff;

  // Loop count, counted branch decrement wins over a write
  // counted branch decrement
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lc_ff <= RST_WORD;
    end else if (clk_en) begin
      if (loop_branch) begin
        lc_ff <= lc_ff - 64'h0000000000000001;
      end else if (wr_ok && ar_req.index == IDX_LOOP_COUNT) begin
        lc_ff <= ar_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  stack_tag_top_a: assert property (
    @(posedge core_clk) disable iff (reset)
    stack_tag_ff[STACK_TAG_TOP] == 1'b0)
    else $error("stack tag top bit set");

  itc_step_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && tick && !wr_itc) |=> itc_ff == $past(itc_ff) + 64'h1)
    else $error("time counter missed a tick");

  itc_read_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && ar_req.rd && ar_req.index == IDX_INTERVAL_TIME
     && !nxt_priv_fault) |=> ar_rdata == $past(itc_ff))
    else $error("time counter read wrong value");

  itc_secure_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && ar_req.rd && itc_secure && ar_req.priv != MOST_PRIV
     && ar_req.index == IDX_INTERVAL_TIME) |=> priv_fault && ar_rdata == 0)
    else $error("secured time read not faulted");

  stamp_gp_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && stamp_rd && itc_secure && current_priv_level != MOST_PRIV)
    |=> gp_fault && $stable(stamp_data))
    else $error("legacy stamp fault missing");

  ruc_halt_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (!cpu_active && !last_halter) |=> $stable(ruc_ff))
    else $error("utilization counted while halted");

  call_copy_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && call_branch) |=> pfs_ff.pfm == $past(current_frame_marker)
      && pfs_ff.pec == $past(ec_ff) && pfs_ff.ppl == $past(current_priv_level))
    else $error("call did not save state");

  ret_priv_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && return_branch) |=> restore_valid
      && restore.priv >= $past(current_priv_level)
      && ec_ff == $past(pfs_ff.pec))
    else $error("return raised privilege");

  pfs_rsv_a: assert property (
    @(posedge core_clk) disable iff (reset)
    pfs_ff.rv_hi == 4'h0 && pfs_ff.rv_lo == 14'h0000)
    else $error("caller state reserved bits set");

  lc_dec_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && loop_branch) |=> lc_ff == $past(lc_ff) - 64'h1)
    else $error("loop count not decremented");

endmodule // app_register_subset

// ===== app_register_subset_test.sv
// Self-checking bench for the application register subset
`timescale 1ns/1ns
module app_register_subset_test
  import app_regs_pkg::*;
;
  // Stimulus, all driven from time zero
  logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, stamp_rd = 1'b0;
  ar_req_t ar_req = '0;
  logic itc_secure = 0, ruc_secure = 0, rse_base_we = 0, rse_spill_adv = 0;
  logic rse_tag_we = 0, rse_tag_val = 0, wide_load_op = 0, fill_load_op = 0;
  logic spill_store_op = 0, spill_tag_val = 0, cpu_active = 1;
  logic last_halter = 0, call_branch = 0, return_branch = 0, loop_branch = 0;
  logic [63:0] rse_base_data = '0, wide_load_hi = '0;
  logic [5:0] rse_tag_bit = '0, user_tag_collection_bit = '0;
  logic [37:0] current_frame_marker = '0;
  logic [1:0] current_priv_level = '0;
  // Observed outputs
  logic [63:0] ar_rdata, stamp_data, wide_store_hi, compare_operand;
  logic [63:0] feature_bits;
  logic priv_fault, reserved_fault, gp_fault, fill_tag, restore_valid;
  restore_t restore;
  logic [5:0] drain_stage_count;
  // Bookkeeping
  int n_mismatch = 0, tests_run = 0, seed = 43;
  logic [63:0] exp_v [6];
  logic [63:0] t0, t1;
  logic [6:0] rw_idx [6] = '{IDX_SPILL_POINTER, IDX_COMPARE_VALUE,
    IDX_USER_TAG, IDX_FLOAT_STATUS, IDX_LOOP_COUNT, IDX_WIDE_STORE};

  app_register_subset dut_u (.core_clk, .reset, .clk_en, .ar_req, .ar_rdata,
    .priv_fault, .reserved_fault, .itc_secure, .ruc_secure, .stamp_rd,
    .stamp_data, .gp_fault, .rse_base_we, .rse_base_data, .rse_spill_adv,
    .rse_tag_we, .rse_tag_bit, .rse_tag_val, .wide_load_op, .wide_load_hi,
    .wide_store_hi, .compare_operand, .spill_store_op, .fill_load_op,
    .user_tag_collection_bit, .spill_tag_val, .fill_tag, .cpu_active, .last_halter,
    .call_branch, .return_branch, .current_frame_marker, .current_priv_level,
    .restore, .restore_valid, .loop_branch, .drain_stage_count, .feature_bits);

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  // Compare and count
  task automatic chk(input string n, input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask

  // One register move, answer sampled after the taking edge
  task automatic acc(input logic w, input logic [6:0] i, input logic [1:0] p,
                     input logic [63:0] d);
    @(posedge core_clk);
    ar_req <= {!w, w, i, p, d};
    @(posedge core_clk);
    ar_req <= '0;
    #1;
  endtask

  // One-cycle hardware event pulse
  task automatic ev(input int k);
    @(posedge core_clk);
    case (k)
      0: call_branch <= 1'b1;
      1: return_branch <= 1'b1;
      2: loop_branch <= 1'b1;
      3: rse_spill_adv <= 1'b1;
      4: rse_base_we <= 1'b1;
      5: rse_tag_we <= 1'b1;
      6: wide_load_op <= 1'b1;
      7: spill_store_op <= 1'b1;
      8: stamp_rd <= 1'b1;
      default: fill_load_op <= 1'b1;
    endcase
    @(posedge core_clk);
    {call_branch, return_branch, loop_branch, rse_spill_adv, rse_base_we,
     rse_tag_we, wide_load_op, spill_store_op, fill_load_op, stamp_rd} <= '0;
    #1;
  endtask

  // Expected caller state word
  function automatic logic [63:0] pfs_word(input logic [1:0] pl,
    input logic [5:0] ec, input logic [37:0] fm);
    return {pl, 4'h0, ec, 14'h0, fm};
  endfunction

  // Return never raises privilege (smaller is more privileged)
  function automatic logic [1:0] ret_priv(input logic [1:0] sv, cur);
    return (sv < cur) ? cur : sv;
  endfunction

  // Verdict
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    acc(0, IDX_CALLER_STATE, 0, 0);
    chk("caller rst", ar_rdata, RST_WORD);
    acc(1, IDX_FRAME_SAVE_BASE, 0, {$random(seed), $random(seed)});
    acc(0, IDX_FRAME_SAVE_BASE, 0, 0);
    chk("base ro", ar_rdata, RST_WORD);
    rse_base_data <= {$random(seed), $random(seed)};
    ev(4);
    acc(0, IDX_FRAME_SAVE_BASE, 0, 0);
    chk("base load", ar_rdata, rse_base_data);
    for (int j = 0; j < 6; j++) begin
      exp_v[j] = {$random(seed), $random(seed)};
      acc(1, rw_idx[j], 0, exp_v[j]);
      acc(0, rw_idx[j], 0, 0);
      chk("rw reg", ar_rdata, exp_v[j]);
    end
    chk("cmp operand", compare_operand, exp_v[1]);
    chk("wide hi", wide_store_hi, exp_v[5]);
    ev(3);
    acc(0, IDX_SPILL_POINTER, 0, 0);
    chk("spill adv", ar_rdata, exp_v[0] + SPILL_STEP);
    ev(2);
    acc(0, IDX_LOOP_COUNT, 0, 0);
    chk("loop dec", ar_rdata, exp_v[4] - 64'h1);
    acc(1, IDX_STACK_TAG, 0, 64'h0);
    rse_tag_bit <= 6'h3F;
    rse_tag_val <= 1'b1;
    ev(5);
    rse_tag_bit <= 6'h05;
    ev(5);
    acc(0, IDX_STACK_TAG, 0, 0);
    chk("stack tag", ar_rdata, 64'h0000000000000020);
    acc(1, IDX_STACK_TAG, 0, 64'hFFFFFFFFFFFFFFFF);
    acc(0, IDX_STACK_TAG, 0, 0);
    chk("tag top", ar_rdata, 64'h7FFFFFFFFFFFFFFF);
    wide_load_hi <= {$random(seed), $random(seed)};
    ev(6);
    acc(0, IDX_WIDE_STORE, 0, 0);
    chk("wide load", wide_store_hi, wide_load_hi);
    acc(1, IDX_USER_TAG, 0, 64'h0);
    user_tag_collection_bit <= 6'h07;
    spill_tag_val <= 1'b1;
    ev(7);
    acc(0, IDX_USER_TAG, 0, 0);
    chk("user tag", ar_rdata, 64'h0000000000000080);
    ev(9);
    chk("fill tag", {63'h0, fill_tag}, 64'h1);
    acc(1, IDX_DRAIN_COUNT, 0, 64'hFFFFFFFFFFFFFFEA);
    acc(0, IDX_DRAIN_COUNT, 0, 0);
    chk("drain", ar_rdata, 64'h000000000000002A);
    t0 = {$random(seed), $random(seed)};
    current_frame_marker <= t0[37:0];
    current_priv_level <= 2'h3;
    ev(0);
    acc(0, IDX_CALLER_STATE, 0, 0);
    chk("call", ar_rdata, pfs_word(2'h3, 6'h2A, t0[37:0]));
    acc(1, IDX_CALLER_STATE, 0, {20'h3D5FF, 6'h3F, t0[37:0]});
    acc(0, IDX_CALLER_STATE, 0, 0);
    chk("pfs rsv", ar_rdata, pfs_word(2'h0, 6'h15, t0[37:0]));
    current_priv_level <= 2'h2;
    ev(1);
    chk("ret valid", {63'h0, restore_valid}, 64'h1);
    chk("ret", {18'h0, restore}, {18'h0, t0[37:0], 6'h15,
        ret_priv(2'h0, 2'h2)});
    chk("ret drain", {58'h0, drain_stage_count}, 64'h15);
    acc(0, IDX_INTERVAL_TIME, 3, 0);
    t1 = ar_rdata;
    acc(0, IDX_INTERVAL_TIME, 3, 0);
    chk("itc step", ar_rdata - t1, 64'h2);
    acc(1, IDX_INTERVAL_TIME, 2, 64'h0);
    chk("itc wr flt", {63'h0, priv_fault}, 64'h1);
    acc(1, IDX_INTERVAL_TIME, 0, 64'hFFFFFFFFFFFFFFFE);
    acc(0, IDX_INTERVAL_TIME, 0, 0);
    chk("itc top", ar_rdata, 64'hFFFFFFFFFFFFFFFF);
    acc(0, IDX_INTERVAL_TIME, 0, 0);
    chk("itc wrap", ar_rdata, 64'h1);
    itc_secure <= 1'b1;
    acc(0, IDX_INTERVAL_TIME, 3, 0);
    chk("itc sec", {ar_rdata[62:0], priv_fault}, 64'h1);
    ev(8);
    chk("stamp flt", {63'h0, gp_fault}, 64'h1);
    chk("stamp hold", stamp_data, RST_WORD);
    current_priv_level <= 2'h0;
    acc(0, IDX_INTERVAL_TIME, 0, 0);
    t1 = ar_rdata;
    ev(8);
    chk("stamp rd", stamp_data - t1, 64'h2);
    chk("stamp ok", {63'h0, gp_fault}, 64'h0);
    cpu_active <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      last_halter <= j[0];
      acc(0, IDX_UTILIZATION, 0, 0);
      t1 = ar_rdata;
      acc(0, IDX_UTILIZATION, 0, 0);
      chk("ruc step", ar_rdata - t1, 64'(2 * j));
    end
    ruc_secure <= 1'b1;
    acc(0, IDX_UTILIZATION, 1, 0);
    chk("ruc sec", {63'h0, priv_fault}, 64'h1);
    chk("ruc feat", {63'h0, feature_bits[FEAT_UTIL_BIT]}, 64'h1);
    acc(0, 7'h14, 0, 0);
    chk("rsv idx", {63'h0, reserved_fault}, 64'h1);
    acc(0, IDX_IGN_A_LO, 0, 0);
    chk("ign idx", {ar_rdata[62:0], reserved_fault}, 64'h0);
    test_done();
  end
endmodule // app_register_subset_test

// ===== app_regs_pkg.sv
// Shared constants and carrier types for the application register subset
package app_regs_pkg;

  // ------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------
  localparam logic [6:0] IDX_FRAME_SAVE_BASE = 7'h11;
  localparam logic [6:0] IDX_SPILL_POINTER = 7'h12;
  localparam logic [6:0] IDX_STACK_TAG = 7'h13;
  localparam logic [6:0] IDX_WIDE_STORE = 7'h19;
  localparam logic [6:0] IDX_COMPARE_VALUE = 7'h20;
  localparam logic [6:0] IDX_USER_TAG = 7'h24;
  localparam logic [6:0] IDX_FLOAT_STATUS = 7'h28;
  localparam logic [6:0] IDX_INTERVAL_TIME = 7'h2C;
  localparam logic [6:0] IDX_UTILIZATION = 7'h2D;
  localparam logic [6:0] IDX_CALLER_STATE = 7'h40;
  localparam logic [6:0] IDX_LOOP_COUNT = 7'h41;
  localparam logic [6:0] IDX_DRAIN_COUNT = 7'h42;
  // Ignored index windows, read as zero without fault
  localparam logic [6:0] IDX_IGN_A_LO = 7'h30;
  localparam logic [6:0] IDX_IGN_A_HI = 7'h3F;
  localparam logic [6:0] IDX_IGN_B_LO = 7'h70;
  localparam logic [6:0] IDX_IGN_B_HI = 7'h7F;

  // ------------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------------
  localparam int STACK_TAG_TOP = 63;
  localparam int WIDE_OPT_HI = 61;
  localparam int WIDE_OPT_LO = 60;
  localparam int FRAME_W = 38;
  localparam int DRAIN_W = 6;
  localparam int FM_SOF_LO = 0;
  localparam int FM_SOL_LO = 7;
  localparam int FM_SOR_LO = 14;
  localparam int FEAT_WIDE_BIT = 2;
  localparam int FEAT_UTIL_BIT = 3;
  localparam logic [1:0] MOST_PRIV = 2'h0;
  localparam logic [63:0] SPILL_STEP = 64'h0000000000000008;

  // ------------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------------
  localparam logic [63:0] RST_WORD = 64'h0000000000000000;
  localparam logic [5:0] RST_DRAIN = 6'h00;
  localparam logic [1:0] RST_PRIV = 2'h0;
  localparam logic [15:0] RST_TICK = 16'h0000;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  // Move-to/from register request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] index;
    logic [1:0] priv;
    logic [63:0] wdata;
  } ar_req_t;

  // Saved caller state layout
  typedef struct packed {
    logic [1:0] ppl;
    logic [3:0] rv_hi;
    logic [5:0] pec;
    logic [13:0] rv_lo;
    logic [37:0] pfm;
  } caller_state_t;

  // Return-branch restore bundle
  typedef struct packed {
    logic [37:0] frame;
    logic [5:0] drain;
    logic [1:0] priv;
  } restore_t;

endpackage
